// ---- verilog/spb_regs.vh ----
// Register map, field positions and reset values for the serial port block
// Included by the serial port core; holds definitions only
`ifndef SPB_REGS_VH
`define SPB_REGS_VH

// ==========================================
// Register indices, then byte offsets (offsets AXI4-Lite word aligned)
`define SPB_POWER_BAUD_CONTROL_IDX      8'h87
`define SPB_TIMER_MODE_CONTROL_IDX      8'h89
`define SPB_SERIAL_CTRL_REG_IDX      8'h98
`define SPB_OFF_POWER_BAUD_CONTROL      10'h21C
`define SPB_OFF_TIMER_MODE_CONTROL      10'h224
`define SPB_OFF_SERIAL_CTRL_REG      10'h260
`define SPB_OFF_SBUF      10'h264
`define SPB_OFF_RELOAD    10'h268
`define SPB_OFF_IEN       10'h26C

// ==========================================
// Field positions
`define SPB_POWER_BAUD_CONTROL_DBL      7
`define SPB_SERIAL_CTRL_REG_RI       0
`define SPB_SERIAL_CTRL_REG_TI       1
`define SPB_SERIAL_CTRL_REG_RB8      2
`define SPB_SERIAL_CTRL_REG_TB8      3
`define SPB_SERIAL_CTRL_REG_REN      4
`define SPB_SERIAL_CTRL_REG_SM2      5
`define SPB_SERIAL_CTRL_REG_SMB      6
`define SPB_SERIAL_CTRL_REG_SMA      7
`define SPB_RELOAD_T2SEL  16

// ==========================================
// Reset values
`define SPB_POWER_BAUD_CONTROL_RST      8'h00
`define SPB_TIMER_MODE_CONTROL_RST      8'h00
`define SPB_SERIAL_CTRL_REG_RST      8'h00
`define SPB_RELOAD_RST    17'h00000

// ==========================================
// Timing counts and AXI4-Lite response codes
`define SPB_MODE0_DIV     8'h0C
`define SPB_T1_PRESCALE   8'h0C
`define SPB_T2_PRESCALE   8'h02
`define SPB_AXI_RESP_OK   2'h0
`define SPB_AXI_RESP_ERR  2'h2

`endif

// ---- verilog/spb_serial_port.v ----
// Four-mode serial port with baud timer and AXI4-Lite register access
// Assumes one 100 MHz clock, async active-low reset, a remote async partner
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "spb_regs.vh"

module spb_serial_port (
	// Clock and reset
	input  wire        clk,
	input  wire        resetn,
	// AXI4-Lite write address
	input  wire [9:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [9:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Serial pins
	input  wire        rxd_in,
	output reg         txd_out,
	output reg         sclk_out,
	// Interrupt request
	output reg         serial_irq
);

	// ==========================================
	// Registers
	reg [7:0]  power_ctrl_reg;
	reg [7:0]  timer_mode_reg;
	reg [7:0]  serial_ctrl_reg;
	reg [16:0] reload_q;
	reg        irq_en_q;
	reg [8:0]  rx_buf_q;
	wire [1:0] smode = {serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_SMA], serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_SMB]};
	wire       dbl   = power_ctrl_reg[`SPB_POWER_BAUD_CONTROL_DBL];

	// ==========================================
	// AXI4-Lite slave: address and data taken in any order, answer after both
	reg        aw_hold_q, w_hold_q;
	reg [9:0]  aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0]  w_strb_q;
	wire       wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	reg        tx_start_d;
	reg        ti_clr, ri_clr;
	reg        wr_ok;

	always @* begin
		wr_ok = 1'b1;
		case (aw_addr_q)
		`SPB_OFF_POWER_BAUD_CONTROL, `SPB_OFF_TIMER_MODE_CONTROL, `SPB_OFF_SERIAL_CTRL_REG,
		`SPB_OFF_SBUF, `SPB_OFF_RELOAD, `SPB_OFF_IEN: wr_ok = 1'b1;
		default: wr_ok = 1'b0;
		endcase
		tx_start_d = wr_go & w_strb_q[0] & (aw_addr_q == `SPB_OFF_SBUF);
		ti_clr = wr_go & w_strb_q[0] & (aw_addr_q == `SPB_OFF_SERIAL_CTRL_REG) & ~w_data_q[`SPB_SERIAL_CTRL_REG_TI];
		ri_clr = wr_go & w_strb_q[0] & (aw_addr_q == `SPB_OFF_SERIAL_CTRL_REG) & ~w_data_q[`SPB_SERIAL_CTRL_REG_RI];
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			aw_addr_q     <= 10'h000;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SPB_AXI_RESP_OK;
		end else begin
			s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `SPB_AXI_RESP_OK : `SPB_AXI_RESP_ERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
			end
		end
	end

	// Read channel; reading the data buffer has no side effect
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SPB_AXI_RESP_OK;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `SPB_AXI_RESP_OK;
				case (s_axi_araddr)
				`SPB_OFF_POWER_BAUD_CONTROL:   s_axi_rdata <= {24'h000000, power_ctrl_reg};
				`SPB_OFF_TIMER_MODE_CONTROL:   s_axi_rdata <= {24'h000000, timer_mode_reg};
				`SPB_OFF_SERIAL_CTRL_REG:   s_axi_rdata <= {24'h000000, serial_ctrl_reg};
				`SPB_OFF_SBUF:   s_axi_rdata <= {24'h000000, rx_buf_q[7:0]};
				`SPB_OFF_RELOAD: s_axi_rdata <= {15'h0000, reload_q};
				`SPB_OFF_IEN:    s_axi_rdata <= {31'h00000000, irq_en_q};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `SPB_AXI_RESP_ERR;
				end
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Register storage; hardware set of a done flag wins over a software clear
	wire       tx_done, rx_done;
	reg        rx_keep;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			power_ctrl_reg  <= `SPB_POWER_BAUD_CONTROL_RST;
			timer_mode_reg  <= `SPB_TIMER_MODE_CONTROL_RST;
			serial_ctrl_reg <= `SPB_SERIAL_CTRL_REG_RST;
			reload_q        <= `SPB_RELOAD_RST;
			irq_en_q        <= 1'b0;
		end else begin
			if (wr_go & w_strb_q[0]) begin
				case (aw_addr_q)
				`SPB_OFF_POWER_BAUD_CONTROL: power_ctrl_reg <= w_data_q[7:0];
				`SPB_OFF_TIMER_MODE_CONTROL: timer_mode_reg <= w_data_q[7:0];
				`SPB_OFF_SERIAL_CTRL_REG: serial_ctrl_reg[7:2] <= w_data_q[7:2];
				`SPB_OFF_IEN:  irq_en_q <= w_data_q[0];
				default: ;
				endcase
			end
			if (wr_go & (aw_addr_q == `SPB_OFF_RELOAD)) begin
				if (w_strb_q[0]) reload_q[7:0] <= w_data_q[7:0];
				if (w_strb_q[1]) reload_q[15:8] <= w_data_q[15:8];
				if (w_strb_q[2]) reload_q[16] <= w_data_q[16];
			end
			if (tx_done)
				serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_TI] <= 1'b1;
			else if (ti_clr)
				serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_TI] <= 1'b0;
			if (rx_done & rx_keep)
				serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_RI] <= 1'b1;
			else if (ri_clr)
				serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_RI] <= 1'b0;
			if (rx_done & rx_keep & smode[1])
				serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_RB8] <= rx_buf_q[8];
		end
	end

	// ==========================================
	// Baud timer: timer 1 auto-reload byte or timer 2 16-bit reload
	reg [7:0]  pre_q;
	reg [15:0] tcnt_q;
	reg        ovf_q, ovf_half_q;
	reg [1:0]  xtal_q;
	wire       use_t2 = reload_q[`SPB_RELOAD_T2SEL];
	wire [7:0] pre_lim = use_t2 ? `SPB_T2_PRESCALE : `SPB_T1_PRESCALE;
	reg        tick16;
	// A reload write restarts the count, else a new rate waits out the old count
	wire       rld_wr = wr_go & (aw_addr_q == `SPB_OFF_RELOAD);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pre_q      <= 8'h00;
			tcnt_q     <= 16'h0000;
			ovf_q      <= 1'b0;
			ovf_half_q <= 1'b0;
			xtal_q     <= 2'h0;
		end else begin
			xtal_q <= xtal_q + 2'h1;
			ovf_q  <= 1'b0;
			if (pre_q == pre_lim - 8'h01) begin
				pre_q <= 8'h00;
				if (use_t2 ? (tcnt_q == 16'hFFFF) : (tcnt_q[7:0] == 8'hFF)) begin
					tcnt_q     <= use_t2 ? reload_q[15:0] : {8'h00, reload_q[15:8]};
					ovf_q      <= 1'b1;
					ovf_half_q <= ~ovf_half_q;
				end else begin
					tcnt_q <= tcnt_q + 16'h0001;
				end
			end else begin
				pre_q <= pre_q + 8'h01;
			end
			if (rld_wr) begin
				pre_q  <= 8'h00;
				tcnt_q <= 16'hFFFF;
			end
		end
	end

	// Sixteen ticks per bit; mode 2 ticks from clock quarter or half
	always @* begin
		case (smode)
		2'h2:    tick16 = dbl ? xtal_q[0] : (xtal_q == 2'h3);
		default: tick16 = ovf_q & (dbl | ovf_half_q) & ~use_t2 | ovf_q & use_t2;
		endcase
	end

	// ==========================================
	// Transmitter: mode 0 shifts 8 bits with clock; others send start/data/stop
	reg [3:0] tx_sub_q;
	reg [3:0] tx_bit_q;
	reg [10:0] tx_sh_q;
	reg       tx_busy_q;
	reg       tx_done_q;
	reg [7:0] m0_cnt_q;
	wire      m0_tick = (m0_cnt_q == `SPB_MODE0_DIV - 8'h01);
	wire [3:0] tx_bits = (smode == 2'h0) ? 4'h8 : (smode[1] ? 4'hB : 4'hA);
	assign tx_done = tx_done_q;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_sub_q  <= 4'h0;
			tx_bit_q  <= 4'h0;
			tx_sh_q   <= 11'h7FF;
			tx_busy_q <= 1'b0;
			tx_done_q <= 1'b0;
			m0_cnt_q  <= 8'h00;
			txd_out   <= 1'b1;
			sclk_out  <= 1'b1;
		end else begin
			tx_done_q <= 1'b0;
			m0_cnt_q  <= m0_tick ? 8'h00 : m0_cnt_q + 8'h01;
			if (tx_start_d & ~tx_busy_q) begin
				tx_busy_q <= 1'b1;
				tx_bit_q  <= 4'h0;
				tx_sub_q  <= 4'h0;
				if (smode == 2'h0)
					tx_sh_q <= {3'h7, w_data_q[7:0]};
				else if (smode[1])
					tx_sh_q <= {1'b1, serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_TB8], w_data_q[7:0], 1'b0};
				else
					tx_sh_q <= {2'h3, w_data_q[7:0], 1'b0};
			end else if (tx_busy_q & ((smode == 2'h0) ? m0_tick : tick16)) begin
				tx_sub_q <= tx_sub_q + 4'h1;
				if (smode == 2'h0)
					sclk_out <= ~tx_sub_q[0];
				if (tx_sub_q == 4'hF || (smode == 2'h0 && tx_sub_q[0])) begin
					tx_sub_q <= 4'h0;
					txd_out  <= tx_sh_q[0];
					tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
					tx_bit_q <= tx_bit_q + 4'h1;
					if (tx_bit_q == tx_bits) begin
						tx_busy_q <= 1'b0;
						tx_done_q <= 1'b1;
						txd_out   <= 1'b1;
						sclk_out  <= 1'b1;
					end
				end
			end
		end
	end

	// ==========================================
	// Receiver: pin passes three flops, change counts when last two agree
	reg [2:0] rx_sync_q;
	reg       rx_lvl_q;
	reg       rx_busy_q;
	reg [3:0] rx_sub_q;
	reg [3:0] rx_bit_q;
	reg [9:0] rx_sh_q;
	reg       rx_done_q;
	// Stop bit is sampled too, so a low last bit cannot restart the receiver
	wire [3:0] rx_bits = smode[1] ? 4'hB : 4'hA;
	assign rx_done = rx_done_q;

	always @* begin
		rx_keep = ~(smode[1] & serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_SM2] & ~rx_buf_q[8]);
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_sync_q <= 3'h7;
			rx_lvl_q  <= 1'b1;
			rx_busy_q <= 1'b0;
			rx_sub_q  <= 4'h0;
			rx_bit_q  <= 4'h0;
			rx_sh_q   <= 10'h000;
			rx_buf_q  <= 9'h000;
			rx_done_q <= 1'b0;
		end else begin
			rx_sync_q <= {rx_sync_q[1:0], rxd_in};
			if (rx_sync_q[2] == rx_sync_q[1])
				rx_lvl_q <= rx_sync_q[2];
			rx_done_q <= 1'b0;
			if (!rx_busy_q) begin
				if (serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_REN] & ~rx_lvl_q & (smode != 2'h0)) begin
					rx_busy_q <= 1'b1;
					rx_sub_q  <= 4'h0;
					rx_bit_q  <= 4'h0;
				end
			end else if (~serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_REN]) begin
				rx_busy_q <= 1'b0;
			end else if (tick16) begin
				rx_sub_q <= rx_sub_q + 4'h1;
				if (rx_sub_q == 4'h7) begin
					rx_sh_q  <= {rx_lvl_q, rx_sh_q[9:1]};
					rx_bit_q <= rx_bit_q + 4'h1;
					if (rx_bit_q == 4'h0 && rx_lvl_q)
						rx_busy_q <= 1'b0;
					if (rx_bit_q == rx_bits - 4'h1) begin
						rx_busy_q <= 1'b0;
						rx_done_q <= 1'b1;
						rx_buf_q  <= smode[1] ? rx_sh_q[9:1] : {rx_lvl_q, rx_sh_q[9:2]};
					end
				end
			end
		end
	end

	// ==========================================
	// Interrupt request held while either flag stands
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			serial_irq <= 1'b0;
		else
			serial_irq <= irq_en_q & (serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_TI] |
				serial_ctrl_reg[`SPB_SERIAL_CTRL_REG_RI]);
	end

endmodule

// ---- tb/spb_serial_port_properties.sv ----
// Checker bound to the serial port top
// Sees only top ports; bus master holds bready and rready while waiting
`timescale 1ns/1ps
module spb_props (
	// Clock, reset, bus
	input logic        clk, resetn, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
	input logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
	input logic [1:0]  s_axi_rresp,
	input logic [9:0]  s_axi_araddr,
	input logic [31:0] s_axi_rdata,
	// Serial side
	input logic        txd_out, serial_irq
);
	// ==========
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held");
	a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid held");
	a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid held");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 10'h300
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
	a_start_len: assert property ($fell(txd_out) |=> !txd_out)
		else $error("start bit short");
	a_irq_cause: assert property ($fell(serial_irq) |->
		$past(s_axi_wready) || $past(s_axi_wready, 2) || $past(s_axi_wready, 3))
		else $error("irq fell without write");
endmodule
bind spb_serial_port spb_props u_props (.*);

// ---- tb/spb_remote_uart.sv ----
// Far serial device: sends frames on request, captures frames sent to it
// Line idles high; start, nine data bits LSB first, stop
`timescale 1ns/1ps
module spb_remote_uart (
	// Clock
	input logic  clk,
	// Serial lines
	input logic  line_in,
	output logic line_out
);
	// ==========
	// Behaviour
	int         rate = 4;
	int         low_len = 0;
	int         nfr = 0;
	logic [8:0] got = 9'h000;
	initial line_out = 1'h1;
	// Ninth bit goes just before the stop bit
	task automatic send(input logic [8:0] f, input int bc);
		logic [10:0] s;
		s = {1'h1, f, 1'h0};
		for (int i = 0; i < 11 * bc; i++) begin
			@(posedge clk);
			line_out <= s[i / bc];
		end
	endtask
	// Falling clock edges keep sampling clear of the launch edge
	always begin
		@(negedge line_in);
		@(negedge clk);
		low_len = 0;
		while (line_in === 1'h0) begin
			low_len++;
			@(negedge clk);
		end
		for (int i = 0; i < 9; i++) begin
			repeat (i ? rate : rate / 2 - 1) @(negedge clk);
			got[i] = line_in;
		end
		nfr++;
	end
endmodule

// ---- tb/tb_top.sv ----
// Testbench for the serial port block
// Drives the register bus and talks to the far serial device model
`timescale 1ns/1ps
module tb_top;
	// ==========
	// Signals
	localparam logic [9:0] off_pwr = 10'h21C, off_tmr = 10'h224, off_sct = 10'h260;
	localparam logic [9:0] off_buf = 10'h264, off_rld = 10'h268, off_ien = 10'h26C;
	logic        clk = 1'h0, resetn = 1'h0;
	logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        rxd_in, txd_out, sclk_out, serial_irq;
	int          errors = 0, n_checks = 0;
	spb_serial_port DUT (.*);
	spb_remote_uart u_far (.clk(clk), .line_in(txd_out), .line_out(rxd_in));
	initial forever #5 clk = ~clk;
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		close_out;
	end
	// ==========
	// Bus and compare tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		bit aw = 0;
		bit w = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw && w)) begin
			@(posedge clk);
			aw |= s_axi_awready === 1'h1;
			w |= s_axi_wready === 1'h1;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk("bresp", er, s_axi_bresp);
	endtask
	task automatic rd(input string n, input logic [9:0] a, input logic [31:0] e,
		input logic [1:0] er = 2'h0);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk(n, e, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
	endtask
	// ==========
	// Scenarios
	task automatic regs_case;
		rd("power", off_pwr, 32'h0);
		rd("tmode", off_tmr, 32'h0);
		rd("sctl", off_sct, 32'h0);
		wr(off_tmr, 32'h5A);
		rd("tmode", off_tmr, 32'h5A);
		wr(off_pwr, 32'h80);
		rd("power", off_pwr, 32'h80);
		wr(off_sct, 32'h2B);
		rd("sctl", off_sct, 32'h28);
		wr(10'h300, 32'hFF, 2'h2);
		rd("unmapped", 10'h300, 32'h0, 2'h2);
	endtask
	task automatic tx_case;
		logic [7:0] sc[4] = '{8'h88, 8'h80, 8'hC8, 8'hC0};
		logic [7:0] pc[4] = '{8'h00, 8'h80, 8'h00, 8'h80};
		logic [7:0] dt[4] = '{8'hA5, 8'hC3, 8'h5B, 8'h97};
		int bits[4] = '{64, 32, 384, 192};
		rd("ien", off_ien, 32'h0);
		wr(off_rld, 32'hFF00);
		wr(off_tmr, 32'h20);
		wr(off_ien, 32'h1);
		for (int i = 0; i < 4; i++) begin
			wr(off_sct, sc[i]);
			wr(off_pwr, pc[i]);
			chk("irq", 32'h0, serial_irq);
			u_far.rate = bits[i];
			wr(off_buf, dt[i]);
			for (int k = 0; k < 6000 && serial_irq !== 1'h1; k++) @(posedge clk);
			chk("start", bits[i], u_far.low_len);
			chk("frame", {sc[i][3], dt[i]}, u_far.got);
			chk("irq", 32'h1, serial_irq);
			rd("sctl", off_sct, sc[i] | 8'h02);
		end
	endtask
	task automatic t2_case;
		wr(off_sct, 32'h40);
		wr(off_rld, 32'h1FFFE);
		u_far.rate = 64;
		wr(off_buf, 32'h69);
		for (int k = 0; k < 1500 && serial_irq !== 1'h1; k++) @(posedge clk);
		chk("start", 64, u_far.low_len);
		chk("frame", 32'h169, u_far.got);
		chk("irq", 32'h1, serial_irq);
	endtask
	// Mode 0 after the other transmit cases: its low data bits look like a start bit to the far model
	task automatic m0_case;
		logic [7:0] cap = 8'h00;
		logic prev = 1'h1;
		int nclk = 0;
		wr(off_sct, 32'h00);
		wr(off_buf, 32'h96);
		for (int k = 0; k < 400 && serial_irq !== 1'h1; k++) begin
			@(posedge clk);
			if (!prev && sclk_out === 1'h1) begin
				cap = {txd_out, cap[7:1]};
				nclk++;
			end
			prev = sclk_out;
		end
		chk("m0 data", 32'h96, cap);
		chk("m0 clocks", 8, nclk);
		chk("irq", 32'h1, serial_irq);
	endtask
	task automatic rx_case;
		logic [7:0] sc[5] = '{8'hD0, 8'hF0, 8'hF0, 8'hC0, 8'hD0};
		logic [8:0] fr[5] = '{9'h13C, 9'h055, 9'h166, 9'h177, 9'h012};
		bit ok[5] = '{1, 0, 1, 0, 1};
		wr(off_rld, 32'hFF00);
		wr(off_pwr, 32'h80);
		for (int i = 0; i < 5; i++) begin
			wr(off_sct, sc[i]);
			u_far.send(fr[i], 192);
			for (int k = 0; k < 48 && serial_irq !== 1'h1; k++) @(posedge clk);
			rd("sctl", off_sct, ok[i] ? sc[i] | {fr[i][8], 2'h1} : sc[i]);
			if (ok[i])
				rd("rxbuf", off_buf, fr[i][7:0]);
		end
	endtask
	task automatic close_out;
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'h1;
		regs_case;
		tx_case;
		t2_case;
		m0_case;
		rx_case;
		close_out;
	end
endmodule
